// >>> core/ocd_top.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Direct bit clear: outputs from divider
// - Direct with select 10b: oscillator to outputs
// - Direct with select 00b: external clock out
// - Select 01b: direct bit has no effect
// - Correction disable clear: duty correction on
// - Correction disable set: raw high/low counts
// - Low phase lasts low count plus one
// - High phase lasts high count plus one
// - Bypass powers divider down, passes input through
// - Sync-ignore clear: divider obeys chip sync
// - Sync-ignore set: chip sync disregarded entirely
// - Force bit ignored while bypass set
// - Four-bit phase offset field, reset zero
// - Forced level always high, as forcing needs the force bit set
// - Start bit picks first output level
module ocd_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [10:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Clock sources and chip sync pins
  input wire logic internal_oscillator,
  input wire logic ext_clk_in,
  input wire logic sync_n,
  // Output pairs
  output logic channel_one_out_a,
  output logic channel_one_out_b,
  output logic channel_two_out_a,
  output logic channel_two_out_b
);
  import ocd_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_meta_q; // First reset stage
  logic rst_sync_q; // Reset used by the whole design

  // Release through two flops; assertion stays asynchronous
  // A release close to an edge can go metastable in the first stage,
  // so only the second stage fans out to the rest of the design
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin inputs
  // All pins are asynchronous to clk
  logic osc_lvl; // Filtered oscillator level
  logic ext_lvl; // Filtered external clock level
  logic sync_lvl; // Filtered chip sync, active high
  logic sync_raw; // Chip sync pin, turned active high

  // Clock pins are sampled by clk, so a source must run well below
  // a quarter of the clk rate or edges are lost in the filter
  // Each pin costs about four clk of latency before logic sees it
  ocd_sync u_sync_osc (
    .clk(clk),
    .rst_n(rst_sync_q),
    .pin(internal_oscillator),
    .level(osc_lvl)
  );

  ocd_sync u_sync_ext (
    .clk(clk),
    .rst_n(rst_sync_q),
    .pin(ext_clk_in),
    .level(ext_lvl)
  );

  // Inverted ahead of the filter so its reset level is the idle level;
  // a filter that came out of reset low would fake a sync pulse
  assign sync_raw = ~sync_n;

  ocd_sync u_sync_chip (
    .clk(clk),
    .rst_n(rst_sync_q),
    .pin(sync_raw),
    .level(sync_lvl)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0] route_q [2]; // Direct route and correction disable
  logic [7:0] ctrl_q [2]; // Bypass, sync-ignore, force, start, phase
  logic [7:0] cnt_q [2]; // High and low counts
  logic [1:0] insel_q; // Divider input select
  logic [8:0] idx; // Word index of the access
  logic req; // New bus request this cycle
  logic wr_lane0; // Write touching the only populated lane

  // Byte address bits [1:0] are ignored; registers sit on word bounds
  assign idx = wb_adr_i[10:2];
  // A request seen while ack is high is the tail of the last one
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Writes with lane 0 disabled are acked but change nothing
  assign wr_lane0 = req & wb_we_i & wb_sel_i[0];

  // Register index of a given kind for a channel
  // Kind 0 is routing, 1 control, anything else the count pair
  function automatic logic [8:0] ocd_idx(input int kind, input int ch);
    logic [8:0] r;
    r = 9'h000;
    unique case (kind)
      0: r = (ch == 0) ? OCD_IDX_CH1_ROUTE : OCD_IDX_CH2_ROUTE;
      1: r = (ch == 0) ? OCD_IDX_CH1_CTRL : OCD_IDX_CH2_CTRL;
      default: r = (ch == 0) ? OCD_IDX_CH1_CNT : OCD_IDX_CH2_CNT;
    endcase
    return r;
  endfunction

  // Per-channel registers; upper byte lanes carry nothing
  // Reset leaves every channel dividing by two from the external clock
  // Routing keeps only its two defined bits; the rest read zero
  // Counts and control take the full byte
  for (genvar c = 0; c < 2; c++) begin : g_regs
    always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
        route_q[c] <= OCD_RST_ROUTE;
        ctrl_q[c] <= OCD_RST_CTRL;
        cnt_q[c] <= OCD_RST_CNT;
      end else if (wr_lane0) begin
        if (idx == ocd_idx(0, c)) begin
          route_q[c] <= {6'h00, wb_dat_i[1:0]};
        end
        if (idx == ocd_idx(1, c)) begin
          ctrl_q[c] <= wb_dat_i[7:0];
        end
        if (idx == ocd_idx(2, c)) begin
          cnt_q[c] <= wb_dat_i[7:0];
        end
      end
    end
  end

  // Input select register
  // Select code 11 is stored as written but acts like 01
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      insel_q <= OCD_RST_INSEL;
    end else if (wr_lane0 && idx == OCD_IDX_INSEL) begin
      insel_q <= wb_dat_i[1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Divider input selection
  logic src_lvl; // Selected divider input level
  logic src_prev_q; // Previous input level
  logic src_rise; // One-cycle pulse per input clock
  logic sync_act; // Chip sync asserted

  // Oscillator only when selected; external clock otherwise
  // Select 01 and 11 keep the external clock on the divider
  assign src_lvl = (insel_q == OCD_SEL_OSC) ? osc_lvl : ext_lvl;
  // The pulse lags the pin by the filter latency, but both channels
  // see the same pulse, so their relative phase is exact
  assign src_rise = src_lvl & ~src_prev_q;
  assign sync_act = sync_lvl;

  // Edge detect on the filtered level, never on a raw stage
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      src_prev_q <= 1'b0;
    end else begin
      src_prev_q <= src_lvl;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Channel dividers and output pairs
  logic [1:0] div_lvl; // Divider output levels
  logic [1:0] running; // Divider counting
  logic [1:0] direct; // Direct route in effect
  logic [1:0] forced; // Static level in effect
  logic [1:0] out_q; // Output pair, true side
  logic [1:0] out_n_q; // Output pair, complement side

  // Both channels share one input pulse and one sync
  for (genvar c = 0; c < 2; c++) begin : g_chan
    ocd_chan u_chan (
      .clk(clk),
      .rst_n(rst_sync_q),
      .src_rise(src_rise),
      .low_cnt(cnt_q[c][OCD_CN_LO_LSB +: 4]),
      .high_cnt(cnt_q[c][OCD_CN_HI_LSB +: 4]),
      .phase(ctrl_q[c][OCD_CT_PH_LSB +: 4]),
      .dcc_off(route_q[c][OCD_RT_DUTY_OFF]),
      .bypass(ctrl_q[c][OCD_CT_BYPASS]),
      .nosync(ctrl_q[c][OCD_CT_NOSYNC]),
      .start_high(ctrl_q[c][OCD_CT_START]),
      .sync_act(sync_act),
      .div_lvl(div_lvl[c]),
      .running(running[c])
    );

    // Select 01b and the undefined 11b leave the divider in the path
    assign direct[c] = route_q[c][OCD_RT_DIRECT]
      && (insel_q == OCD_SEL_OSC || insel_q == OCD_SEL_EXT);
    // Forcing needs sync-ignore, and bypass overrides it
    assign forced[c] = ctrl_q[c][OCD_CT_NOSYNC] && ctrl_q[c][OCD_CT_FORCE]
      && !ctrl_q[c][OCD_CT_BYPASS];

    // Output pair: direct route, bypass, forced level, then divider
    // Direct route outranks bypass, so a direct pair ignores the divider
    // Forced level comes only with sync-ignore set, as forced[c] itself requires it
    // The complement side is a flop of its own, not an inverter on out_q,
    // so both pins switch on the same edge
    always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
        out_q[c] <= 1'b0;
        out_n_q[c] <= 1'b1;
      end else if (direct[c] && insel_q == OCD_SEL_OSC) begin
        out_q[c] <= osc_lvl;
        out_n_q[c] <= ~osc_lvl;
      end else if (direct[c]) begin
        out_q[c] <= ext_lvl;
        out_n_q[c] <= ~ext_lvl;
      end else if (ctrl_q[c][OCD_CT_BYPASS]) begin
        out_q[c] <= src_lvl;
        out_n_q[c] <= ~src_lvl;
      end else if (forced[c]) begin
        out_q[c] <= ctrl_q[c][OCD_CT_FORCE];
        out_n_q[c] <= ~ctrl_q[c][OCD_CT_FORCE];
      end else begin
        out_q[c] <= div_lvl[c];
        out_n_q[c] <= ~div_lvl[c];
      end
    end
  end

  assign channel_one_out_a = out_q[0];
  assign channel_one_out_b = out_n_q[0];
  assign channel_two_out_a = out_q[1];
  assign channel_two_out_b = out_n_q[1];
  // Pins are straight flop outputs, with no logic after the flops

  //////////////////////////////////////////////////////////////////////////////
  // Bus answer
  logic [7:0] rd_byte; // Addressed register contents
  logic ack_q; // Acknowledge flop
  logic [31:0] dat_q; // Read data flop

  // Read mux; unmapped words read zero
  // Later matches win; no two indices collide
  // Status is live: output levels, divider activity and sync
  always_comb begin
    rd_byte = 8'h00;
    for (int c = 0; c < 2; c++) begin
      if (idx == ocd_idx(0, c)) begin
        rd_byte = route_q[c];
      end
      if (idx == ocd_idx(1, c)) begin
        rd_byte = ctrl_q[c];
      end
      if (idx == ocd_idx(2, c)) begin
        rd_byte = cnt_q[c];
      end
    end
    if (idx == OCD_IDX_INSEL) begin
      rd_byte = {6'h00, insel_q};
    end
    if (idx == OCD_IDX_STATUS) begin
      rd_byte = 8'h00;
      rd_byte[OCD_ST_OUT_LSB +: 2] = out_q;
      rd_byte[OCD_ST_RUN_LSB +: 2] = running;
      rd_byte[OCD_ST_SYNC] = sync_act;
    end
  end

  // One-cycle ack for every request, mapped or not
  // Ack is registered: every request costs one wait state, which keeps
  // the read mux off the bus output path
  // Read data holds until the next read, so a write leaves it as it was
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (req && !wb_we_i) begin
        dat_q <= {24'h00_0000, rd_byte};
      end
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_sync_q);
  // Each output check but pair_compl_a looks one clk back, as every output is a flop
  // Sync timing checks live in the channel module; bypass is checked here

  // A second ack in a row would take the request twice
  bus_ack_once_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle");

  for (genvar c = 0; c < 2; c++) begin : g_chk
    divider_route_a: assert property (!route_q[c][OCD_RT_DIRECT]
      && !ctrl_q[c][OCD_CT_BYPASS] && !forced[c] |=> out_q[c] == $past(div_lvl[c]))
      else $error("output not from divider");
    osc_direct_a: assert property (route_q[c][OCD_RT_DIRECT]
      && insel_q == OCD_SEL_OSC |=> out_q[c] == $past(osc_lvl))
      else $error("oscillator not routed");
    ext_direct_a: assert property (route_q[c][OCD_RT_DIRECT]
      && insel_q == OCD_SEL_EXT |=> out_q[c] == $past(ext_lvl))
      else $error("external clock not routed");
    sel_noeffect_a: assert property (insel_q == OCD_SEL_NONE
      && !ctrl_q[c][OCD_CT_BYPASS] && !forced[c] |=> out_q[c] == $past(div_lvl[c]))
      else $error("direct bit acted on select 01");
    bypass_pass_a: assert property (ctrl_q[c][OCD_CT_BYPASS] && !direct[c]
      |=> out_q[c] == $past(src_lvl) && !running[c])
      else $error("bypass not passing input");
    force_level_a: assert property (!direct[c] && !ctrl_q[c][OCD_CT_BYPASS]
      && ctrl_q[c][OCD_CT_NOSYNC] && ctrl_q[c][OCD_CT_FORCE] |=> out_q[c] && !out_n_q[c])
      else $error("forced level not driven");
    force_ignored_a: assert property (ctrl_q[c][OCD_CT_BYPASS] && !direct[c]
      && ctrl_q[c][OCD_CT_FORCE] && !src_lvl |=> !out_q[c])
      else $error("force acted under bypass");
    pair_compl_a: assert property (out_q[c] != out_n_q[c])
      else $error("output pair not complementary");
    route_osc_c: cover property (direct[c] && insel_q == OCD_SEL_OSC ##1 $rose(out_q[c]));
    force_c: cover property (forced[c] ##1 out_q[c]);
  end

  sync_restart_c: cover property (sync_act ##1 !sync_act ##[1:40] running[0] && running[1]);
  bypass_c: cover property (ctrl_q[0][OCD_CT_BYPASS] ##1 $rose(channel_one_out_a));
endmodule // ocd_top

// >>> include/ocd_pkg.sv
package ocd_pkg;
  // Register indices; byte address is four times the index
  localparam logic [8:0] OCD_IDX_CH1_CNT = 9'h193;
  localparam logic [8:0] OCD_IDX_CH1_CTRL = 9'h194;
  localparam logic [8:0] OCD_IDX_CH1_ROUTE = 9'h195;
  localparam logic [8:0] OCD_IDX_CH2_CNT = 9'h196;
  localparam logic [8:0] OCD_IDX_CH2_CTRL = 9'h197;
  localparam logic [8:0] OCD_IDX_CH2_ROUTE = 9'h198;
  localparam logic [8:0] OCD_IDX_INSEL = 9'h1e1;
  localparam logic [8:0] OCD_IDX_STATUS = 9'h1f0;
  // Routing register fields
  localparam int OCD_RT_DIRECT = 1;
  localparam int OCD_RT_DUTY_OFF = 0;
  // Control register fields
  localparam int OCD_CT_BYPASS = 7;
  localparam int OCD_CT_NOSYNC = 6;
  localparam int OCD_CT_FORCE = 5;
  localparam int OCD_CT_START = 4;
  localparam int OCD_CT_PH_LSB = 0;
  // Count register fields: high in low nibble, low in high nibble
  localparam int OCD_CN_HI_LSB = 0;
  localparam int OCD_CN_LO_LSB = 4;
  // Status register fields
  localparam int OCD_ST_OUT_LSB = 0;
  localparam int OCD_ST_RUN_LSB = 2;
  localparam int OCD_ST_SYNC = 4;
  // Reset values
  localparam logic [7:0] OCD_RST_ROUTE = 8'h00;
  localparam logic [7:0] OCD_RST_CTRL = 8'h00;
  localparam logic [7:0] OCD_RST_CNT = 8'h00;
  localparam logic [1:0] OCD_RST_INSEL = 2'h0;
  // Input select codes
  localparam logic [1:0] OCD_SEL_EXT = 2'h0;
  localparam logic [1:0] OCD_SEL_NONE = 2'h1;
  localparam logic [1:0] OCD_SEL_OSC = 2'h2;
  // Timing counts in divider input cycles
  localparam logic [4:0] OCD_ONE_CYC = 5'h01;
  localparam logic [4:0] OCD_PERIOD_EXTRA = 5'h02;
  // Divider sequencer states
  typedef enum logic [1:0] {
    OCD_HOLD = 2'b00,
    OCD_DELAY = 2'b01,
    OCD_RUN = 2'b10
  } ocd_state_t;
endpackage

// >>> core/ocd_sync.sv
`timescale 1ns/1ps
module ocd_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous level in, filtered level out
  input wire logic pin,
  output logic level
);
  logic s1_q; // Metastable stage, read by s2 only
  logic s2_q;
  logic s3_q;
  logic lvl_q; // Accepted level

  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
    end
  end
  assign level = lvl_q;
endmodule // ocd_sync

// >>> core/ocd_chan.sv
`timescale 1ns/1ps
module ocd_chan (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Divider input clock edge
  input wire logic src_rise,
  // Configuration
  input wire logic [3:0] low_cnt,
  input wire logic [3:0] high_cnt,
  input wire logic [3:0] phase,
  input wire logic dcc_off,
  input wire logic bypass,
  input wire logic nosync,
  input wire logic start_high,
  // Chip-level sync, active high here
  input wire logic sync_act,
  // Divider state
  output logic div_lvl,
  output logic running
);
  import ocd_pkg::*;
  ocd_state_t st_q; // Sequencer state
  logic [4:0] cnt_q; // Input cycles in this phase
  logic lvl_q; // Divider output level
  logic [5:0] total; // Full period in input cycles, up to 32
  logic [4:0] hi_len;
  logic [4:0] lo_len;
  logic [4:0] cur_len;
  logic [4:0] ph_last;
  logic halt; // Held by sync or bypass

  // Phase lengths; correction evens out the two halves
  always_comb begin
    total = 6'(low_cnt) + 6'(high_cnt) + 6'(OCD_PERIOD_EXTRA);
    if (dcc_off) begin
      hi_len = 5'(high_cnt) + OCD_ONE_CYC;
      lo_len = 5'(low_cnt) + OCD_ONE_CYC;
    end else begin
      hi_len = 5'(total >> 1);
      lo_len = 5'(total - 6'(hi_len));
    end
    cur_len = lvl_q ? hi_len : lo_len;
    ph_last = 5'(phase) - OCD_ONE_CYC;
    halt = (sync_act & ~nosync) | bypass;
  end

  // Sequencer: hold, phase delay, then alternate low and high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= OCD_HOLD;
      cnt_q <= 5'h00;
      lvl_q <= 1'b0;
    end else if (halt) begin
      st_q <= OCD_HOLD;
      cnt_q <= 5'h00;
      lvl_q <= start_high;
    end else begin
      unique case (st_q)
        OCD_HOLD: begin
          cnt_q <= 5'h00;
          lvl_q <= start_high;
          st_q <= (phase == 4'h0) ? OCD_RUN : OCD_DELAY;
        end
        OCD_DELAY: begin
          if (src_rise) begin
            cnt_q <= (cnt_q == ph_last) ? 5'h00 : cnt_q + OCD_ONE_CYC;
            if (cnt_q == ph_last) begin
              st_q <= OCD_RUN;
            end
          end
        end
        OCD_RUN: begin
          if (src_rise && cnt_q >= cur_len - OCD_ONE_CYC) begin
            lvl_q <= ~lvl_q;
            cnt_q <= 5'h00;
          end else if (src_rise) begin
            cnt_q <= cnt_q + OCD_ONE_CYC;
          end
        end
        default: st_q <= OCD_HOLD;
      endcase
    end
  end
  assign div_lvl = lvl_q;
  assign running = (st_q == OCD_RUN);

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  high_phase_len_a: assert property ((st_q == OCD_RUN) && !halt && src_rise && lvl_q
    && (cnt_q < hi_len - OCD_ONE_CYC) |=> lvl_q) else $error("high phase ended early");
  low_phase_end_a: assert property ((st_q == OCD_RUN) && !halt && src_rise && !lvl_q
    && (cnt_q == lo_len - OCD_ONE_CYC) |=> lvl_q) else $error("low phase not ended");
  sync_restart_a: assert property (sync_act && !nosync |=>
    (st_q == OCD_HOLD) && (lvl_q == $past(start_high))) else $error("sync not obeyed");
  sync_ignore_a: assert property (nosync && !bypass && (st_q == OCD_RUN) && !src_rise
    |=> (st_q == OCD_RUN) && $stable(lvl_q)) else $error("sync not ignored");
  phase_delay_a: assert property ((st_q == OCD_DELAY) && !halt && src_rise
    && (cnt_q != ph_last) |=> st_q == OCD_DELAY) else $error("phase delay cut short");
  run_toggle_c: cover property ((st_q == OCD_RUN) ##1 $rose(lvl_q) ##[1:40] $fell(lvl_q));
endmodule // ocd_chan

// >>> bench/tb.sv
`timescale 1ns/1ps
module tb;
  import ocd_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // Source rates in clk cycles; distinct so routing shows in the period
  localparam int EXT_H = 3; // External half period
  localparam int OSC_H = 2; // Oscillator half period
  localparam int SP = 2 * EXT_H; // One divider input cycle
  // Clock, reset and bus
  logic clk;
  logic rst_n;
  logic wb_cyc_i, wb_stb_i, wb_we_i;
  logic [10:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  // Pins
  logic internal_oscillator, ext_clk_in, sync_n;
  logic channel_one_out_a, channel_one_out_b, channel_two_out_a, channel_two_out_b;
  // Bookkeeping
  int num_errors;
  int tests_run;
  int ph_cnt;

  ocd_top i_ocd_top (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .internal_oscillator(internal_oscillator),
    .ext_clk_in(ext_clk_in), .sync_n(sync_n), .channel_one_out_a(channel_one_out_a),
    .channel_one_out_b(channel_one_out_b), .channel_two_out_a(channel_two_out_a),
    .channel_two_out_b(channel_two_out_b));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Free-running sources, launched on the rising edge
  always @(posedge clk) begin
    ph_cnt <= ph_cnt + 1;
    if ((ph_cnt % EXT_H) == EXT_H - 1) ext_clk_in <= ~ext_clk_in;
    if ((ph_cnt % OSC_H) == OSC_H - 1) internal_oscillator <= ~internal_oscillator;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Common tasks
  task summarize;
    if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; entered right after a rising edge
  task wb_xfer(input logic [8:0] idx, input logic we, input logic [7:0] wd,
               output logic [31:0] rd);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= {24'h000000, wd};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    // Bounded wait; a missing ack counts as a fault
    if (n >= 40) begin
      num_errors++;
      $display("[ERR] %0t bus ack missing", $time);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk);
  endtask

  task wr(input logic [8:0] idx, input logic [7:0] d);
    logic [31:0] x;
    wb_xfer(idx, 1'b1, d, x);
  endtask

  // Full word compared, so upper lanes must read zero
  task rd_chk(input logic [8:0] idx, input logic [7:0] exp);
    logic [31:0] x;
    wb_xfer(idx, 1'b0, 8'h00, x);
    check(x, {24'h000000, exp});
  endtask

  function automatic logic outa(input int ch);
    return (ch == 1) ? channel_one_out_a : channel_two_out_a;
  endfunction

  function automatic logic outb(input int ch);
    return (ch == 1) ? channel_one_out_b : channel_two_out_b;
  endfunction

  // Lengths of one full high and low phase, in clk cycles
  task meas(input int ch, input int exp_hi, input int exp_lo);
    int hi, lo, n;
    hi = 0;
    lo = 0;
    n = 0;
    // Settle time lets a fresh setting take over before counting
    repeat (40) @(posedge clk);
    @(negedge clk);
    while (outa(ch) !== 1'b0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    while (outa(ch) !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    while (outa(ch) === 1'b1 && hi < 300) begin
      @(negedge clk);
      hi++;
    end
    check(outb(ch), 1'b1);
    while (outa(ch) === 1'b0 && lo < 300) begin
      @(negedge clk);
      lo++;
    end
    check(hi, exp_hi);
    check(lo, exp_lo);
    @(posedge clk);
  endtask

  // Output must stay at one level for a span
  task hold(input int ch, input logic lvl, input int cyc);
    int bad;
    bad = 0;
    for (int i = 0; i < cyc; i++) begin
      @(negedge clk);
      if (outa(ch) !== lvl) bad++;
    end
    check(bad, 0);
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_reset;
    rd_chk(OCD_IDX_CH1_ROUTE, 8'h00);
    rd_chk(OCD_IDX_CH2_ROUTE, 8'h00);
    rd_chk(OCD_IDX_CH1_CTRL, 8'h00);
    rd_chk(OCD_IDX_CH2_CTRL, 8'h00);
    rd_chk(OCD_IDX_CH1_CNT, 8'h00);
    rd_chk(OCD_IDX_CH2_CNT, 8'h00);
    rd_chk(OCD_IDX_INSEL, 8'h00);
    rd_chk(9'h100, 8'h00);
    meas(1, SP, SP);
  endtask

  task t_rw;
    wr(OCD_IDX_CH2_CNT, 8'ha5);
    rd_chk(OCD_IDX_CH2_CNT, 8'ha5);
    wr(OCD_IDX_CH1_CTRL, 8'h0f);
    rd_chk(OCD_IDX_CH1_CTRL, 8'h0f);
    // Unmapped writes must leave no trace
    wr(9'h100, 8'hff);
    rd_chk(9'h100, 8'h00);
    wr(OCD_IDX_CH2_CNT, 8'h00);
    wr(OCD_IDX_CH1_CTRL, 8'h00);
    // Lane 0 disabled: the write is acked and dropped
    wb_sel_i <= 4'he;
    wr(OCD_IDX_CH2_CNT, 8'h33);
    wb_sel_i <= 4'hf;
    rd_chk(OCD_IDX_CH2_CNT, 8'h00);
  endtask

  task t_div;
    wr(OCD_IDX_CH1_CNT, 8'h12);
    wr(OCD_IDX_CH1_ROUTE, 8'h01);
    meas(1, 3 * SP, 2 * SP);
    wr(OCD_IDX_CH1_ROUTE, 8'h00);
    // Odd total: correction gives the extra cycle to low
    meas(1, 2 * SP, 3 * SP);
  endtask

  task t_bypass;
    wr(OCD_IDX_CH1_CTRL, 8'he0);
    meas(1, EXT_H, EXT_H);
  endtask

  task t_force;
    wr(OCD_IDX_CH1_CTRL, 8'h60);
    repeat (10) @(posedge clk);
    hold(1, 1'b1, 60);
    wr(OCD_IDX_CH1_CTRL, 8'h40);
    meas(1, 2 * SP, 3 * SP);
    wr(OCD_IDX_CH1_CTRL, 8'h00);
  endtask

  task t_direct;
    wr(OCD_IDX_CH1_ROUTE, 8'h02);
    meas(1, EXT_H, EXT_H);
    wr(OCD_IDX_INSEL, 8'h02);
    meas(1, OSC_H, OSC_H);
    wr(OCD_IDX_INSEL, 8'h01);
    meas(1, 2 * SP, 3 * SP);
    wr(OCD_IDX_CH1_ROUTE, 8'h00);
    wr(OCD_IDX_INSEL, 8'h00);
  endtask

  task t_sync;
    wr(OCD_IDX_CH1_CTRL, 8'h10);
    wr(OCD_IDX_CH2_CTRL, 8'h40);
    sync_n <= 1'b0;
    repeat (10) @(posedge clk);
    hold(1, 1'b1, 60);
    meas(2, SP, SP);
    sync_n <= 1'b1;
    repeat (10) @(posedge clk);
  endtask

  // Same counts on both; only the offset separates their restart
  task t_phase;
    int t1, t2;
    t1 = -1;
    t2 = -1;
    wr(OCD_IDX_CH1_CTRL, 8'h00);
    wr(OCD_IDX_CH1_CNT, 8'h00);
    wr(OCD_IDX_CH2_CTRL, 8'h02);
    sync_n <= 1'b0;
    repeat (20) @(posedge clk);
    hold(1, 1'b0, 10);
    hold(2, 1'b0, 10);
    // Both held low and stopped, sync seen
    rd_chk(OCD_IDX_STATUS, 8'h10);
    sync_n <= 1'b1;
    for (int i = 0; i < 300; i++) begin
      @(negedge clk);
      if (t1 < 0 && channel_one_out_a === 1'b1) t1 = i;
      if (t2 < 0 && channel_two_out_a === 1'b1) t2 = i;
    end
    check(t2 - t1, 2 * SP);
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 11'h000;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h00000000;
    internal_oscillator = 1'b0;
    ext_clk_in = 1'b0;
    sync_n = 1'b1;
    num_errors = 0;
    tests_run = 0;
    ph_cnt = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_rw;
    t_div;
    t_bypass;
    t_force;
    t_direct;
    t_sync;
    t_phase;
    summarize;
  end

  // Run needs under two thousand cycles; this is well past that
  initial begin
    #200000;
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize;
  end
endmodule // tb
